// ---- bench/cpu_data_memory_port_chk.sv ----
// port-level assertions for the data-side memory port
`timescale 1ns/1ns
module cpu_data_memory_port_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wait_state_enable_i,
  input wire logic cancel_i,
  input wire logic resp_valid_o,
  input wire dmem_port_pkg::resp_t resp_o,
  input wire logic debug_halt_o,
  input wire logic data_req_n_o,
  input wire logic [1:0] access_size_o,
  input wire logic sequential_access_o,
  input wire logic more_sequential_follows_o,
  input wire logic speculative_hint_n_o,
  input wire logic cancel_prev_request_o,
  input wire logic [31:0] read_data_i,
  input wire logic data_access_fault_i,
  input wire logic debug_watch_halt_i
);
  import dmem_port_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_issue;
    wait_state_enable_i && !data_req_n_o;
  endsequence
  sequence s_watched;
    s_issue ##0 debug_watch_halt_i;
  endsequence
  a_hint_excl: assert property (speculative_hint_n_o || data_req_n_o)
    else $error("hint with request");
  a_size_legal: assert property (access_size_o != SIZE_RSVD)
    else $error("reserved size");
  a_kill_follows: assert property (s_issue ##0 cancel_i |=> cancel_prev_request_o)
    else $error("kill missing");
  a_kill_cause: assert property (cancel_prev_request_o && $past(wait_state_enable_i)
    |-> !$past(data_req_n_o) && $past(cancel_i)) else $error("kill without cause");
  a_resp_data: assert property (resp_valid_o && !resp_o.write && $past(wait_state_enable_i)
    |-> resp_o.rdata == $past(read_data_i) && resp_o.fault == $past(data_access_fault_i))
    else $error("response data wrong");
  a_resp_timing: assert property (resp_valid_o && $past(wait_state_enable_i)
    && $past(wait_state_enable_i, 2) |-> !$past(data_req_n_o, 2)) else $error("stray response");
  a_watch_halts: assert property (s_watched |=> debug_halt_o)
    else $error("no halt");
  a_halt_blocks: assert property (debug_halt_o && $past(debug_halt_o)
    && $past(wait_state_enable_i) |-> data_req_n_o) else $error("issue while halted");
  a_flags_req: assert property (sequential_access_o || more_sequential_follows_o
    |-> !data_req_n_o || !speculative_hint_n_o) else $error("flags without access");
endmodule

bind cpu_data_memory_port cpu_data_memory_port_chk i_cpu_data_memory_port_chk (.clk_i,
  .reset_n_i, .wait_state_enable_i, .cancel_i, .resp_valid_o, .resp_o, .debug_halt_o,
  .data_req_n_o, .access_size_o, .sequential_access_o, .more_sequential_follows_o,
  .speculative_hint_n_o, .cancel_prev_request_o, .read_data_i, .data_access_fault_i,
  .debug_watch_halt_i);

// ---- bench/cpu_data_memory_port_tb_top.sv ----
// self-checking bench for the data-side memory port
`timescale 1ns/1ns
module cpu_data_memory_port_tb_top;
  import dmem_port_pkg::*;
  typedef struct packed {req_t r; logic [1:0] sm;} exp_t;
  logic clk_i, reset_n_i, wait_state_enable_i, req_valid_i, cancel_i, debug_resume_i, rnd;
  logic req_ready_o, resp_valid_o, debug_halt_o, data_req_n_o, read_write_dir_o;
  logic sequential_access_o, more_sequential_follows_o, access_locked_o, privilege_level_o;
  logic speculative_hint_n_o, cancel_prev_request_o, data_access_fault_i, debug_watch_halt_i;
  logic [1:0] access_size_o;
  logic [4:0] data_proc_mode_o;
  logic [3:0] burst_length_o;
  logic [31:0] data_addr_bus_o, write_data_o, read_data_i;
  req_t req_i, r;
  resp_t resp_o;
  exp_t e;
  exp_t iss_q[$];
  resp_t rsp_q[$];
  int err_total, samples_checked, seed, cyc, left, spec_sent, spec_seen, n;
  logic wd_pend;
  logic [31:0] wd_exp;

  cpu_data_memory_port i_cpu_data_memory_port (.clk_i, .reset_n_i, .wait_state_enable_i,
    .req_valid_i, .req_i, .req_ready_o, .cancel_i, .debug_resume_i, .resp_valid_o, .resp_o,
    .debug_halt_o, .data_addr_bus_o, .data_req_n_o, .read_write_dir_o, .access_size_o,
    .sequential_access_o, .more_sequential_follows_o, .access_locked_o,
    .speculative_hint_n_o, .privilege_level_o, .data_proc_mode_o, .cancel_prev_request_o,
    .burst_length_o, .write_data_o, .read_data_i, .data_access_fault_i, .debug_watch_halt_i);
  dmem_mem_model i_dmem_mem_model (.clk_i, .en_i(wait_state_enable_i),
    .req_n_i(data_req_n_o), .addr_i(data_addr_bus_o), .rdata_o(read_data_i),
    .fault_o(data_access_fault_i), .watch_o(debug_watch_halt_i));

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic req_t mk(input logic [31:0] a, input logic w, input logic [1:0] sz,
                              input logic [3:0] b);
    mk = {a, $random(seed), sz, w, 1'b0, a[4], a[9:5], 1'b0, b};
  endfunction
  // beat bookkeeping mirrors the order in which entries are taken
  task automatic note(input req_t q);
    logic s;
    if (q.spec) begin
      spec_sent++;
    end else begin
      s = left != 0;
      left = s ? left - 1 : (q.burst == 0 ? 0 : q.burst - 1);
      iss_q.push_back({q, s, left != 0});
    end
  endtask
  task automatic send(input req_t q);
    int k;
    req_valid_i = 1;
    req_i = q;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (!(wait_state_enable_i && req_ready_o) && k < 300);
    note(q);
    #1;
  endtask
  task automatic idle(input int c);
    req_valid_i = 0;
    for (int k = 0; k < c && (iss_q.size() > 0 || rsp_q.size() > 0); k++) begin
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end
  always @(posedge clk_i) begin
    if (rnd) begin
      #1;
      wait_state_enable_i = ($random(seed) % 4) != 0;
      cancel_i = ($random(seed) % 8) == 0;
    end
  end
  always @(posedge clk_i) begin
    if (reset_n_i && wait_state_enable_i && !speculative_hint_n_o) spec_seen++;
    // store data belongs to the access cycle, so it is due one enabled edge later
    if (reset_n_i && wait_state_enable_i && wd_pend) begin
      chk(write_data_o === wd_exp, "wdata");
      wd_pend = 0;
    end
    if (reset_n_i && wait_state_enable_i && !data_req_n_o) begin
      if (iss_q.size() == 0) begin
        chk(0, "extra access");
      end else begin
        e = iss_q.pop_front();
        chk(data_addr_bus_o === e.r.addr && read_write_dir_o === e.r.write, "addr");
        chk(access_size_o === (e.r.size == SIZE_RSVD ? SIZE_WORD : e.r.size), "size");
        chk(privilege_level_o === e.r.priv && data_proc_mode_o === e.r.mode, "mode");
        chk(access_locked_o === e.r.lock && burst_length_o === e.r.burst, "lock");
        chk({sequential_access_o, more_sequential_follows_o} === e.sm, "seq");
        wd_pend = e.r.write;
        wd_exp = e.r.wdata;
        if (!cancel_i) rsp_q.push_back({e.r.write ? 32'h0 : e.r.addr ^ 32'hA5A5_5A5A,
                                        e.r.addr[31:28] == 4'hF, e.r.write});
      end
    end
    if (reset_n_i && wait_state_enable_i && resp_valid_o) begin
      if (rsp_q.size() == 0) chk(0, "extra response");
      else chk(resp_o === rsp_q.pop_front(), "response");
    end
  end

  initial begin
    seed = 60;
    {err_total, samples_checked, cyc, left, spec_sent, spec_seen, rnd, wd_pend} = '0;
    {reset_n_i, req_valid_i, cancel_i, debug_resume_i} = '0;
    wait_state_enable_i = 1;
    req_i = '0;
    repeat (12) @(posedge clk_i);
    chk(data_req_n_o === 1 && speculative_hint_n_o === 1 &&
        access_size_o === SIZE_WORD, "rst");
    #1 reset_n_i = 1;
    @(posedge clk_i);
    #1;
    for (int i = 0; i < 8; i++) send(mk(32'h100 + 4 * i, i[0], i[2:1], 4'h0));
    for (int i = 0; i < 4; i++) send(mk(32'h200 + 4 * i, 1'b0, SIZE_WORD, 4'h4));
    for (int i = 0; i < 3; i++) begin
      r = mk(32'h2000 + 4 * i, 1'b1, SIZE_WORD, 4'h0);
      r.lock = i < 2;
      send(r);
    end
    r = mk(32'h300, 1'b0, SIZE_WORD, 4'h0);
    r.spec = 1;
    send(r);
    send(mk(32'hF000_0010, 1'b0, SIZE_WORD, 4'h0));
    idle(100);
    send(mk(32'h0800, 1'b0, SIZE_HALF, 4'h0));
    req_valid_i = 0;
    cancel_i = 1;
    repeat (5) @(posedge clk_i);
    #1 cancel_i = 0;
    idle(100);
    send(mk(32'h0000_0400, 1'b0, SIZE_WORD, 4'h0));
    idle(20);
    chk(debug_halt_o === 1, "halt");
    n = 0;
    req_valid_i = 1;
    repeat (40) begin
      req_i = mk(($random(seed) & 32'h0FFF_FFFC) | 32'h0001_0000, 1'b0, SIZE_WORD, 4'h0);
      @(posedge clk_i);
      if (req_ready_o) begin
        n++;
        note(req_i);
      end
      #1;
    end
    chk(n == FIFO_DEPTH + 1 && req_ready_o === 0, "fill");
    req_valid_i = 0;
    debug_resume_i = 1;
    @(posedge clk_i);
    #1 debug_resume_i = 0;
    idle(300);
    rnd = 1;
    repeat (60) send(mk(($random(seed) & 32'hF000_FFFC) | 32'h0001_0000, $random(seed),
                        $random(seed), 4'h0));
    rnd = 0;
    idle(2);
    wait_state_enable_i = 1;
    cancel_i = 0;
    idle(400);
    chk(spec_seen == spec_sent && iss_q.size() == 0 && rsp_q.size() == 0, "drain");
    tally_and_finish;
  end
endmodule

// ---- bench/dmem_mem_model.sv ----
// far-side data memory that answers each access of the port
`timescale 1ns/1ns
module dmem_mem_model #(
  parameter logic [31:0] WATCH_ADDR = 32'h0000_0400
) (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic req_n_i,
  input wire logic [31:0] addr_i,
  output logic [31:0] rdata_o,
  output logic fault_o,
  output logic watch_o
);
  initial rdata_o = 32'h0;
  initial fault_o = 1'b0;
  // stalled edges are skipped so a frozen request is served once
  always @(posedge clk_i) begin
    if (en_i && !req_n_i) begin
      rdata_o <= addr_i ^ 32'hA5A5_5A5A;
      fault_o <= addr_i[31:28] == 4'hF;
    end else if (en_i) begin
      // stale answers are scrambled once the access cycle is over
      rdata_o <= ~rdata_o;
      fault_o <= ~fault_o;
    end
  end
  assign watch_o = !req_n_i && addr_i == WATCH_ADDR;
endmodule

// ---- common/dmem_port_pkg.sv ----
// shared types and constants for the data-side memory port
// Notes on behaviour
// - request low exactly when next cycle accesses
// - direction low read, high write
// - size 10 word, 01 half, 00 byte
// - sequential high when continuing previous access
// - lookahead high when another sequential follows
// - lock high marks indivisible access sequence
// - speculative hint low announces possible need
// - hint never together with data request
// - privilege low user, high supervisor
// - five-bit mode valid with address
// - kill cancels request of previous cycle
// - four-bit burst length of transfer
// - watchpoint at request end halts core
// - core drives write data on writes
// - byte address on 32-bit address bus
// - outputs change, inputs sampled, rising edge
package dmem_port_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int MODE_W = 5;
  localparam int BURST_W = 4;
  localparam int FIFO_DEPTH = 32;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_RSVD = 2'h3;

  localparam logic DIR_READ = 1'b0;
  localparam logic DIR_WRITE = 1'b1;
  localparam logic PRIV_USER = 1'b0;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [MODE_W-1:0] MODE_RESET = 5'h13;
  localparam logic [BURST_W-1:0] BURST_RESET = 4'h0;

  // one queued access from the load/store unit
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] size;
    logic write;
    logic lock;
    logic priv;
    logic [MODE_W-1:0] mode;
    logic spec;
    logic [BURST_W-1:0] burst;
  } req_t;

  // completion of one access back to the load/store unit
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic fault;
    logic write;
  } resp_t;

  localparam int REQ_W = $bits(req_t);

endpackage

// ---- hw/burst_tracker.sv ----
// counts beats within a burst to derive sequential and lookahead flags
`timescale 1ns/1ns
module burst_tracker #(
  parameter int BW = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic issue_i,
  input wire logic [BW-1:0] burst_i,
  output logic next_seq_o,
  output logic next_more_o
);
  logic [BW-1:0] beats_left;
  logic [BW-1:0] next_left;

  always_comb begin
    next_seq_o = (beats_left != '0);
    if (next_seq_o) begin
      next_left = beats_left - 1'b1;
    end else if (burst_i == '0) begin
      next_left = '0;
    end else begin
      next_left = burst_i - 1'b1;
    end
    next_more_o = (next_left != '0);
  end

  // a zero length is taken as a single beat
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      beats_left <= '0;
    end else if (en_i && issue_i) begin
      beats_left <= next_left;
    end
  end

endmodule

// ---- hw/cpu_data_memory_port.sv ----
// data-side memory port: queues accesses and drives the memory pins
`timescale 1ns/1ns
module cpu_data_memory_port (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wait_state_enable_i,
  input wire logic req_valid_i,
  input wire dmem_port_pkg::req_t req_i,
  output logic req_ready_o,
  input wire logic cancel_i,
  input wire logic debug_resume_i,
  output logic resp_valid_o,
  output dmem_port_pkg::resp_t resp_o,
  output logic debug_halt_o,
  output logic [dmem_port_pkg::ADDR_W-1:0] data_addr_bus_o,
  output logic data_req_n_o,
  output logic read_write_dir_o,
  output logic [1:0] access_size_o,
  output logic sequential_access_o,
  output logic more_sequential_follows_o,
  output logic access_locked_o,
  output logic speculative_hint_n_o,
  output logic privilege_level_o,
  output logic [dmem_port_pkg::MODE_W-1:0] data_proc_mode_o,
  output logic cancel_prev_request_o,
  output logic [dmem_port_pkg::BURST_W-1:0] burst_length_o,
  output logic [dmem_port_pkg::DATA_W-1:0] write_data_o,
  input wire logic [dmem_port_pkg::DATA_W-1:0] read_data_i,
  input wire logic data_access_fault_i,
  input wire logic debug_watch_halt_i
);
  import dmem_port_pkg::*;

  logic en;
  logic head_valid;
  logic [REQ_W-1:0] head_bits;
  req_t head;
  logic issue;
  logic issue_real;
  logic next_seq;
  logic next_more;
  logic [1:0] next_size;
  // access announced at the end of the current cycle
  logic annc_valid;
  logic annc_write;
  logic [DATA_W-1:0] annc_wdata;
  // access taking place in the current cycle
  logic acc_valid;
  logic acc_write;
  logic acc_killed;

  // all state holds still while the wait-state enable is low
  assign en = wait_state_enable_i;
  assign head = req_t'(head_bits);
  // nothing new is offered to memory while halted for debug
  assign issue = head_valid && !debug_halt_o;
  assign issue_real = issue && !head.spec;

  req_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(en),
    .in_valid_i(req_valid_i),
    .in_data_i(REQ_W'(req_i)),
    .in_ready_o(req_ready_o),
    .out_valid_o(head_valid),
    .out_data_o(head_bits),
    .out_ready_i(issue)
  );

  burst_tracker #(
    .BW(BURST_W)
  ) u_burst (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(en),
    .issue_i(issue_real),
    .burst_i(head.burst),
    .next_seq_o(next_seq),
    .next_more_o(next_more)
  );

  // the reserved size code is never put on the pins; it degrades to a word
  always_comb begin
    next_size = head.size;
    if (head.size == SIZE_RSVD) begin
      next_size = SIZE_WORD;
    end
  end

  // request and hint are mutually exclusive by construction
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_req_n_o <= 1'b1;
      speculative_hint_n_o <= 1'b1;
    end else if (en) begin
      data_req_n_o <= !issue_real;
      speculative_hint_n_o <= !(issue && head.spec);
    end
  end

  // address and qualifiers change only when something is issued
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_addr_bus_o <= ADDR_RESET;
      read_write_dir_o <= DIR_READ;
      access_size_o <= SIZE_WORD;
      privilege_level_o <= PRIV_USER;
      data_proc_mode_o <= MODE_RESET;
      burst_length_o <= BURST_RESET;
    end else if (en && issue) begin
      data_addr_bus_o <= head.addr;
      read_write_dir_o <= head.write;
      access_size_o <= next_size;
      privilege_level_o <= head.priv;
      data_proc_mode_o <= head.mode;
      burst_length_o <= head.burst;
    end
  end

  // sequence flags fall back low on idle cycles
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sequential_access_o <= 1'b0;
      more_sequential_follows_o <= 1'b0;
    end else if (en) begin
      sequential_access_o <= issue_real && next_seq;
      more_sequential_follows_o <= issue_real && next_more;
    end
  end

  // lock holds over idle gaps so a locked pair cannot be split; the
  // entry that ends the sequence carries lock low and releases it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      access_locked_o <= 1'b0;
    end else if (en && issue_real) begin
      access_locked_o <= head.lock;
    end
  end

  // announce stage: what the pins promise for the next cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      annc_valid <= 1'b0;
      annc_write <= DIR_READ;
      annc_wdata <= DATA_RESET;
    end else if (en) begin
      annc_valid <= issue_real;
      if (issue_real) begin
        annc_write <= head.write;
        annc_wdata <= head.wdata;
      end
    end
  end

  // access stage: the cycle after the announcement
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_valid <= 1'b0;
      acc_write <= DIR_READ;
      acc_killed <= 1'b0;
      cancel_prev_request_o <= 1'b0;
    end else if (en) begin
      acc_valid <= annc_valid;
      acc_write <= annc_write;
      acc_killed <= annc_valid && cancel_i;
      cancel_prev_request_o <= annc_valid && cancel_i;
    end
  end

  // store data stands through the write cycle and holds afterwards
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      write_data_o <= DATA_RESET;
    end else if (en && annc_valid && annc_write) begin
      write_data_o <= annc_wdata;
    end
  end

  // memory inputs are same-clock logic, sampled at the end of the access
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resp_valid_o <= 1'b0;
      resp_o <= '0;
    end else if (en) begin
      resp_valid_o <= acc_valid && !acc_killed;
      if (acc_valid && !acc_killed) begin
        resp_o.write <= acc_write;
        resp_o.fault <= data_access_fault_i;
        resp_o.rdata <= acc_write ? DATA_RESET : read_data_i;
      end
    end
  end

  // watch sampled at the end of the request cycle; a new hit beats resume
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      debug_halt_o <= 1'b0;
    end else if (en) begin
      if (annc_valid && debug_watch_halt_i) begin
        debug_halt_o <= 1'b1;
      end else if (debug_resume_i) begin
        debug_halt_o <= 1'b0;
      end
    end
  end

endmodule

// ---- hw/req_fifo.sv ----
// request queue with registered head word and honest full flag
`timescale 1ns/1ns
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic push;
  logic load;

  assign push = en_i && in_valid_i && in_ready_o;
  // the head register refills whenever it is empty or being taken
  assign load = en_i && (count != '0) && (!out_valid_o || out_ready_i);

  always_comb begin
    next_count = count;
    if (push && !load) begin
      next_count = count + 1'b1;
    end else if (load && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
    end else if (en_i) begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (load) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready_o <= (next_count != CNT_FULL);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (en_i) begin
      if (load) begin
        out_valid_o <= 1'b1;
        out_data_o <= mem[rd_ptr];
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end

endmodule
